// file: verilog/counter_latch_readback.sv
`timescale 1ns/1ns
// Function
// - access bits zero capture addressed count
// - reads return held value, counting continues
// - high-only, low-only, or low-then-high access
// - pair mode toggles byte flip; host pairs
// - top bits 11, bit0 zero is readback
// - select bits 1..3 choose counters 0..2
// - count-capture-n low captures selected counts together
// - status-capture-n low snapshots status, next read
// - status: out, null, access, mode, decimal
// - null flag set until count transferred
// - decimal bit selects binary or BCD counting
// - full readback pair: status, low, high
// - captures ignored until held count fully read
// - status read ahead of pending held count
// - top bits 00/01/10 pick counter, 11 readback
// - ports at offsets 14 to 17 hex
module counter_latch_readback (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // host i/o port, asynchronous pins
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWrData,
   output logic [7:0] hostRdData,
   // counter pins, asynchronous
   input wire logic [2:0] countClock,
   input wire logic [2:0] countGate,
   output logic [2:0] countOut
);

   // ==================================================
   // helpers
   function automatic logic [15:0] count_down(input logic [15:0] value, input logic decimal);
      logic [15:0] result;
      logic borrow;
      result = value;
      borrow = 1'b1;
      if (decimal) begin
         for (int d = 0; d < 4; d++) begin
            if (borrow) begin
               if (value[4*d +: 4] == 4'h0) begin
                  result[4*d +: 4] = 4'h9;
               end else begin
                  result[4*d +: 4] = value[4*d +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end else begin
         result = value - 16'h0001;
      end
      return result;
   endfunction

   function automatic logic [7:0] pick_byte(input logic [15:0] value, input logic upper);
      return upper ? value[15:8] : value[7:0];
   endfunction

   // ==================================================
   // synchronisers: stage one feeds stage two only
   counter_latch_pkg::host_bus_s busMeta_q, busSync_q;
   logic busWriteOld_q, busReadOld_q;
   logic [2:0] clkMeta_q, clkSync_q, clkOld_q, gateMeta_q, gateSync_q;

   always_ff @(posedge clk) begin
      busMeta_q <= '{write: hostWrite, read: hostRead, addr: hostAddr, data: hostWrData};
      busSync_q <= busMeta_q;
      clkMeta_q <= countClock;
      clkSync_q <= clkMeta_q;
      gateMeta_q <= countGate;
      gateSync_q <= gateMeta_q;
      busWriteOld_q <= busSync_q.write;
      busReadOld_q <= busSync_q.read;
      clkOld_q <= clkSync_q;
   end

   // ==================================================
   // decode
   // address and data must be stable while the strobe is up; they are sampled on its synced rise
   wire writeEdge = busSync_q.write & ~busWriteOld_q;
   wire readEdge = busSync_q.read & ~busReadOld_q;
   wire [7:0] cmd = busSync_q.data;
   wire [7:0] portIdx = busSync_q.addr - counter_latch_pkg::COUNTER0_OFF;
   wire portHit = (busSync_q.addr >= counter_latch_pkg::COUNTER0_OFF) &&
                  (busSync_q.addr < counter_latch_pkg::CONTROL_OFF);
   wire controlWrite = writeEdge && (busSync_q.addr == counter_latch_pkg::CONTROL_OFF);
   wire [1:0] targetSel = cmd[counter_latch_pkg::TARGET_SELECT_HIGH:counter_latch_pkg::TARGET_SELECT_LOW];
   wire [1:0] cmdAccess = cmd[counter_latch_pkg::ACCESS_MODE_HIGH:counter_latch_pkg::ACCESS_MODE_LOW];
   // readback with bit 0 set is reserved and does nothing
   wire isReadback = (targetSel == counter_latch_pkg::SELECT_READBACK);
   wire readbackOk = isReadback && !cmd[counter_latch_pkg::READBACK_MARK_BIT];
   wire rbCount = readbackOk && !cmd[counter_latch_pkg::COUNT_CAPTURE_N];
   wire rbStatus = readbackOk && !cmd[counter_latch_pkg::STATUS_CAPTURE_N];
   wire [2:0] rbSelect = cmd[counter_latch_pkg::SELECT_FIRST_COUNTER +: 3];

   logic [2:0] hitCtrl, captureCmd, statusCmd, progCmd, dataWrite, dataRead, countTick;
   always_comb begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         hitCtrl[i] = controlWrite && !isReadback && (targetSel == 2'(i));
         captureCmd[i] = (hitCtrl[i] && cmdAccess == counter_latch_pkg::ACCESS_CAPTURE) ||
                         (rbCount && rbSelect[i]);
         statusCmd[i] = rbStatus && rbSelect[i];
         progCmd[i] = hitCtrl[i] && cmdAccess != counter_latch_pkg::ACCESS_CAPTURE;
         dataWrite[i] = writeEdge && portHit && (portIdx == 8'(i));
         dataRead[i] = readEdge && portHit && (portIdx == 8'(i));
         countTick[i] = clkSync_q[i] & ~clkOld_q[i] & gateSync_q[i];
      end
   end

   // ==================================================
   // per-counter state
   counter_latch_pkg::counter_ctrl_s ctrl_q [3];
   logic [15:0] element_q [3];
   logic [15:0] loadValue_q [3];
   logic [15:0] hold_q [3];
   logic [7:0] snapshot_q [3];
   logic [2:0] holdFull_q, snapFull_q, loadPend_q, nullCount_q, readFlip_q, writeFlip_q, out_q;

   // ==================================================
   // read selection for the addressed counter
   logic [1:0] rdIdx;
   logic [7:0] readMux;
   logic upperByte;
   always_comb begin
      rdIdx = portHit ? portIdx[1:0] : 2'h0;
      upperByte = (ctrl_q[rdIdx].access == counter_latch_pkg::ACCESS_HIGH) ||
                  (ctrl_q[rdIdx].access == counter_latch_pkg::ACCESS_PAIR && readFlip_q[rdIdx]);
      if (!portHit) begin
         readMux = counter_latch_pkg::UNMAPPED_READ;
      end else if (snapFull_q[rdIdx]) begin
         readMux = snapshot_q[rdIdx];
      end else if (holdFull_q[rdIdx]) begin
         readMux = pick_byte(hold_q[rdIdx], upperByte);
      end else begin
         // live bytes may tear while counting runs; host must stop the counter first
         readMux = pick_byte(element_q[rdIdx], upperByte);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hostRdData <= counter_latch_pkg::READ_RESET;
      end else if (readEdge) begin
         hostRdData <= readMux;
      end
   end

   // ==================================================
   // counters, captures and byte sequencing
   // counting here is a plain down count; the timing mode is only stored and reported in status, the output pin ignores it
   logic [2:0] pairMode, loadDone, transfer, flipRead, holdRelease, snapRelease;
   always_comb begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         pairMode[i] = (ctrl_q[i].access == counter_latch_pkg::ACCESS_PAIR);
         // a single-byte load completes at once, a pair load on its high byte
         loadDone[i] = dataWrite[i] && (ctrl_q[i].access == counter_latch_pkg::ACCESS_LOW ||
                       ctrl_q[i].access == counter_latch_pkg::ACCESS_HIGH || (pairMode[i] && writeFlip_q[i]));
         transfer[i] = countTick[i] && loadPend_q[i];
         // a status read leaves the byte flip where it is
         flipRead[i] = dataRead[i] && !snapFull_q[i] && pairMode[i];
         holdRelease[i] = dataRead[i] && !snapFull_q[i] && holdFull_q[i] &&
                          (!pairMode[i] || readFlip_q[i]);
         snapRelease[i] = dataRead[i] && snapFull_q[i];
      end
   end

   // programming rewrites access mode, counting mode and decimal select
   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n) begin
            ctrl_q[i] <= counter_latch_pkg::CTRL_RESET;
         end else if (progCmd[i]) begin
            ctrl_q[i] <= '{access: cmdAccess,
                           mode: cmd[counter_latch_pkg::COUNT_MODE_B2:counter_latch_pkg::COUNT_MODE_B0],
                           decimal: cmd[counter_latch_pkg::DECIMAL_BIT]};
         end
      end
   end

   // read and write keep separate byte flips; programming clears both
   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n || progCmd[i]) begin
            readFlip_q[i] <= 1'b0;
            writeFlip_q[i] <= 1'b0;
         end else begin
            if (flipRead[i]) begin
               readFlip_q[i] <= ~readFlip_q[i];
            end
            if (dataWrite[i] && pairMode[i]) begin
               writeFlip_q[i] <= ~writeFlip_q[i];
            end
         end
      end
   end

   // a pending load transfers on the next input clock rise with the gate high; a load completed in that cycle stays pending
   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n) begin
            element_q[i] <= counter_latch_pkg::COUNT_RESET;
            loadPend_q[i] <= 1'b0;
         end else begin
            if (transfer[i]) begin
               element_q[i] <= loadValue_q[i];
            end else if (countTick[i]) begin
               element_q[i] <= count_down(element_q[i], ctrl_q[i].decimal);
            end
            if (loadDone[i]) begin
               loadPend_q[i] <= 1'b1;
            end else if (transfer[i]) begin
               loadPend_q[i] <= 1'b0;
            end
         end
      end
   end

   // the set wins over the transfer, so a count written during a transfer still reads as null
   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n) begin
            nullCount_q[i] <= 1'b0;
         end else if (progCmd[i] || loadDone[i]) begin
            nullCount_q[i] <= 1'b1;
         end else if (transfer[i]) begin
            nullCount_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n || progCmd[i]) begin
            out_q[i] <= 1'b0;
         end else if (countTick[i] && !loadPend_q[i] && element_q[i] == 16'h0001) begin
            out_q[i] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n) begin
            loadValue_q[i] <= counter_latch_pkg::COUNT_RESET;
         end else if (dataWrite[i]) begin
            case (ctrl_q[i].access)
               counter_latch_pkg::ACCESS_LOW: begin
                  loadValue_q[i] <= {8'h00, cmd};
               end
               counter_latch_pkg::ACCESS_HIGH: begin
                  loadValue_q[i] <= {cmd, 8'h00};
               end
               counter_latch_pkg::ACCESS_PAIR: begin
                  if (writeFlip_q[i]) begin
                     loadValue_q[i][15:8] <= cmd;
                  end else begin
                     loadValue_q[i][7:0] <= cmd;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // count capture is refused while a held count is unread
   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n) begin
            hold_q[i] <= counter_latch_pkg::COUNT_RESET;
            holdFull_q[i] <= 1'b0;
         end else if (captureCmd[i] && !holdFull_q[i]) begin
            hold_q[i] <= element_q[i];
            holdFull_q[i] <= 1'b1;
         end else if (holdRelease[i]) begin
            holdFull_q[i] <= 1'b0;
         end
      end
   end

   // a status snapshot is refused while an earlier one is unread
   always_ff @(posedge clk) begin
      for (int i = 0; i < counter_latch_pkg::NUM_COUNTERS; i++) begin
         if (!reset_n) begin
            snapshot_q[i] <= counter_latch_pkg::READ_RESET;
            snapFull_q[i] <= 1'b0;
         end else if (statusCmd[i] && !snapFull_q[i]) begin
            snapshot_q[i] <= {out_q[i], nullCount_q[i], ctrl_q[i]};
            snapFull_q[i] <= 1'b1;
         end else if (snapRelease[i]) begin
            snapFull_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         countOut <= 3'h0;
      end else begin
         countOut <= out_q;
      end
   end

endmodule // counter_latch_readback

// file: verilog/counter_latch_pkg.sv
package counter_latch_pkg;

   // ==================================================
   // port map
   localparam int NUM_COUNTERS = 3;
   localparam logic [7:0] COUNTER0_OFF = 8'h14;
   localparam logic [7:0] CONTROL_OFF = 8'h17;

   // ==================================================
   // control byte fields
   localparam int TARGET_SELECT_HIGH = 7;
   localparam int TARGET_SELECT_LOW = 6;
   localparam int ACCESS_MODE_HIGH = 5;
   localparam int ACCESS_MODE_LOW = 4;
   localparam int COUNT_MODE_B2 = 3;
   localparam int COUNT_MODE_B0 = 1;
   localparam int DECIMAL_BIT = 0;
   localparam logic [1:0] SELECT_READBACK = 2'h3;

   // ==================================================
   // readback command fields
   localparam int COUNT_CAPTURE_N = 5;
   localparam int STATUS_CAPTURE_N = 4;
   localparam int SELECT_FIRST_COUNTER = 1;
   localparam int READBACK_MARK_BIT = 0;

   // ==================================================
   // access modes
   localparam logic [1:0] ACCESS_CAPTURE = 2'h0;
   localparam logic [1:0] ACCESS_LOW = 2'h1;
   localparam logic [1:0] ACCESS_HIGH = 2'h2;
   localparam logic [1:0] ACCESS_PAIR = 2'h3;

   // ==================================================
   // reset values
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] READ_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // per-counter programming, also bits 5..0 of the status snapshot
   typedef struct packed {
      logic [1:0] access;
      logic [2:0] mode;
      logic decimal;
   } counter_ctrl_s;

   localparam counter_ctrl_s CTRL_RESET = '{access: ACCESS_PAIR, mode: 3'h0, decimal: 1'b0};

   // host bus sample after synchronisation
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] data;
   } host_bus_s;

endpackage

// file: test/counter_latch_readback_asserts.sv
`timescale 1ns/1ns
// =====
// port checks
module counter_latch_readback_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // host port
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWrData,
   input wire logic [7:0] hostRdData,
   // counter pins
   input wire logic [2:0] countClock,
   input wire logic [2:0] countGate,
   input wire logic [2:0] countOut
);
   // copies of the pin synchronisers, so actions line up with the design
   logic [2:0] wrSync_q, rdSync_q, clk1_q, clk2_q, clk3_q;
   logic [7:0] addr1_q, addr2_q, data1_q, data2_q;
   logic [2:0] gate1_q, gate2_q;
   wire wrAct = wrSync_q[1] & ~wrSync_q[2];
   wire rdAct = rdSync_q[1] & ~rdSync_q[2];
   wire [2:0] tickAct = clk2_q & ~clk3_q & gate2_q;
   wire [2:0] prog = (wrAct && addr2_q == 8'h17 && data2_q[5:4] != 2'h0) ? 3'h1 << data2_q[7:6] : 3'h0;
   always_ff @(posedge clk) begin
      wrSync_q <= {wrSync_q[1:0], hostWrite};
      rdSync_q <= {rdSync_q[1:0], hostRead};
      clk1_q <= countClock;
      clk2_q <= clk1_q;
      clk3_q <= clk2_q;
      gate1_q <= countGate;
      gate2_q <= gate1_q;
      addr1_q <= hostAddr;
      addr2_q <= addr1_q;
      data1_q <= hostWrData;
      data2_q <= data1_q;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_rd_only_read: assert property (!rdAct |=> $stable(hostRdData))
      else $error("read data moved without a read");
   a_bad_port_zero: assert property (rdAct && (addr2_q < 8'h14 || addr2_q > 8'h16) |=> hostRdData == 8'h00)
      else $error("control or unmapped read not zero");
   a_prog_clears_out: assert property (prog != 3'h0 |-> ##2 (countOut & $past(prog, 2)) == 3'h0)
      else $error("programming left output high");
   a_out_rise_tick: assert property ($rose(countOut[0]) |-> $past(tickAct[0], 2))
      else $error("output rose without a tick");
   a_out_rise_one: assert property ($rose(countOut[1]) |-> $past(tickAct[1], 2))
      else $error("output rose without a tick");
   a_out_rise_two: assert property ($rose(countOut[2]) |-> $past(tickAct[2], 2))
      else $error("output rose without a tick");
   a_out_has_cause: assert property ($changed(countOut) |-> $past(wrAct || tickAct != 3'h0, 2))
      else $error("output changed without cause");
   a_reset_values: assert property ($rose(reset_n) |-> hostRdData == 8'h00 && countOut == 3'h0)
      else $error("outputs not cleared by reset");
   a_rd_hold_steady: assert property ($changed(hostRdData) |=> $stable(hostRdData) [*4])
      else $error("read data did not stand");
endmodule // counter_latch_readback_asserts

bind counter_latch_readback counter_latch_readback_asserts counter_latch_readback_asserts_inst (
   .clk(clk), .reset_n(reset_n), .hostWrite(hostWrite), .hostRead(hostRead), .hostAddr(hostAddr),
   .hostWrData(hostWrData), .hostRdData(hostRdData), .countClock(countClock), .countGate(countGate),
   .countOut(countOut));

// file: test/host_bus_model.sv
`timescale 1ns/1ns
// =====
// host processor on the byte port
module host_bus_model (
   // clock
   input wire logic clk,
   // host port
   output logic hostWrite,
   output logic hostRead,
   output logic [7:0] hostAddr,
   output logic [7:0] hostWrData,
   // read sample point
   output logic rdTaken
);
   initial begin
      hostWrite = 1'b0;
      hostRead = 1'b0;
      hostAddr = 8'h00;
      hostWrData = 8'h00;
      rdTaken = 1'b0;
   end
   // strobes stand 4 cycles each way, one more than the synchronisers need
   task automatic access(input logic isWr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      hostAddr = addr;
      hostWrData = data;
      hostWrite = isWr;
      hostRead = !isWr;
      repeat (4) @(negedge clk);
      rdTaken = !isWr;
      hostWrite = 1'b0;
      hostRead = 1'b0;
      // a released bus never shows the old value
      hostAddr = ~addr;
      hostWrData = ~data;
      @(negedge clk);
      rdTaken = 1'b0;
      repeat (3) @(negedge clk);
   endtask
endmodule // host_bus_model

// file: test/counter_latch_readback_tb.sv
`timescale 1ns/1ns
// =====
// bench
module counter_latch_readback_tb;
   logic clk, reset_n, hostWrite, hostRead, rdTaken;
   logic [7:0] hostAddr, hostWrData, hostRdData, r1, r2;
   logic [2:0] countClock, countGate, countOut;
   logic [7:0] expQ[$];
   int bad_count, samples_checked, cycles, seed;
   counter_latch_readback counter_latch_readback_inst (.clk(clk), .reset_n(reset_n), .hostWrite(hostWrite),
      .hostRead(hostRead), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
      .countClock(countClock), .countGate(countGate), .countOut(countOut));
   host_bus_model host_bus_model_inst (.clk(clk), .hostWrite(hostWrite), .hostRead(hostRead),
      .hostAddr(hostAddr), .hostWrData(hostWrData), .rdTaken(rdTaken));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic test_done();
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_bus_model_inst.access(1'b1, a, d);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host_bus_model_inst.access(1'b0, a, 8'h00);
   endtask
   // counter clocks stand 4 cycles each way so the synchronisers see them
   task automatic tick(input logic [2:0] m);
      countClock = m;
      repeat (4) @(negedge clk);
      countClock = 3'h0;
      repeat (4) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // =====
   // read watcher and timeout
   always @(posedge clk) begin
      if (rdTaken === 1'b1) begin
         chk(hostRdData, expQ.pop_front());
      end
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         test_done();
      end
   end
   // =====
   // main sequence
   initial begin
      reset_n = 1'b0;
      countClock = 3'h0;
      countGate = 3'h7;
      seed = 33;
      bad_count = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      wr(8'h17, 8'h34);
      wr(8'h14, 8'h03);
      wr(8'h14, 8'h01);
      wr(8'h17, 8'he2);
      rdx(8'h14, 8'h74);
      tick(3'h1);
      wr(8'h17, 8'h00);
      tick(3'h1);
      tick(3'h1);
      wr(8'h17, 8'h00);
      rdx(8'h14, 8'h03);
      rdx(8'h14, 8'h01);
      tick(3'h1);
      wr(8'h17, 8'hc2);
      rdx(8'h14, 8'h34);
      rdx(8'h14, 8'h00);
      rdx(8'h14, 8'h01);
      wr(8'h17, 8'h00);
      wr(8'h17, 8'he2);
      rdx(8'h14, 8'h34);
      rdx(8'h14, 8'h00);
      rdx(8'h14, 8'h01);
      $display("test capture and readback done");
      wr(8'h14, 8'h02);
      wr(8'h14, 8'h00);
      tick(3'h1);
      tick(3'h1);
      tick(3'h1);
      chk({5'h00, countOut}, 8'h01);
      wr(8'h17, 8'he2);
      rdx(8'h14, 8'hb4);
      $display("test output status done");
      r1 = 8'($random(seed));
      r2 = 8'($random(seed));
      wr(8'h17, 8'h50);
      wr(8'h15, r1);
      wr(8'h17, 8'ha0);
      wr(8'h16, r2);
      tick(3'h6);
      wr(8'h17, 8'hdc);
      tick(3'h6);
      rdx(8'h15, r1);
      rdx(8'h16, r2);
      $display("test group capture done");
      wr(8'h17, 8'h53);
      wr(8'h15, 8'h10);
      tick(3'h2);
      tick(3'h2);
      rdx(8'h15, 8'h09);
      wr(8'h18, 8'hff);
      rdx(8'h17, 8'h00);
      rdx(8'h18, 8'h00);
      rdx(8'h13, 8'h00);
      countGate = 3'h5;
      tick(3'h2);
      rdx(8'h15, 8'h09);
      countGate = 3'h7;
      $display("test decimal and ports done");
      reset_n = 1'b0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      chk({5'h00, countOut}, 8'h00);
      wr(8'h17, 8'he2);
      rdx(8'h14, 8'h30);
      rdx(8'h15, 8'h00);
      $display("test reset in mid-run done");
      repeat (2) @(negedge clk);
      test_done();
   end
endmodule // counter_latch_readback_tb
